// file: fsr_consts.svh
// Constants for the fault status register group
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH
`define FSR_REG_W            16
`define FSR_FAULT_W          5
`define FSR_STD_W            8
`define FSR_BIT_EXCESS_CUR   0
`define FSR_BIT_EXCESS_VOLT  1
`define FSR_BIT_EXCESS_PWR   2
`define FSR_BIT_REVERSED     3
`define FSR_BIT_THERMAL      4
`define FSR_STB_FAULT_BIT    3
`define FSR_STB_STD_BIT      5
`define FSR_STD_VALID_MASK   8'h3D
`define FSR_ZERO16           16'h0000
`define FSR_ZERO8            8'h00
`define FSR_ZERO5            5'h00
`endif

// file: fsr_pkg.sv
// Types shared by the fault status register group
package fsr_pkg;
    typedef enum logic [2:0] {
        fsr_sel_live,
        fsr_sel_mask,
        fsr_sel_events,
        fsr_sel_rise,
        fsr_sel_fall,
        fsr_sel_std_events,
        fsr_sel_std_mask,
        fsr_sel_none
    } fsr_sel_e;
endpackage

// file: fsr_top.sv
// Fault status register group with rise/fall filters, read-clear events and summary bits
`include "fsr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fsr_top
(
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic [`FSR_FAULT_W-1:0]  fault_in,
    input  wire logic [`FSR_STD_W-1:0]    std_src,
    input  wire logic                     cmd_valid,
    input  wire logic                     cmd_write,
    input  wire fsr_pkg::fsr_sel_e        cmd_sel,
    input  wire logic [`FSR_REG_W-1:0]    cmd_wdata,
    output logic                          rsp_valid,
    output logic [`FSR_REG_W-1:0]         rsp_data,
    output logic [7:0]                    status_byte
);
    import fsr_pkg::*;

    typedef struct packed {
        logic [`FSR_FAULT_W-1:0] sync_a;
        logic [`FSR_FAULT_W-1:0] sync_b;
        logic [`FSR_FAULT_W-1:0] live;
        logic [`FSR_REG_W-1:0]   rise_f;
        logic [`FSR_REG_W-1:0]   fall_f;
        logic [`FSR_REG_W-1:0]   mask;
        logic [`FSR_REG_W-1:0]   events;
        logic [`FSR_STD_W-1:0]   std_prev;
        logic [`FSR_STD_W-1:0]   std_events;
        logic [`FSR_STD_W-1:0]   std_mask;
        logic                    rsp_valid;
        logic [`FSR_REG_W-1:0]   rsp_data;
        logic [7:0]              status_byte;
    } fsr_state_s;

    fsr_state_s q;
    fsr_state_s next_q;
    logic [`FSR_REG_W-1:0] hit;
    logic [`FSR_STD_W-1:0] std_hit;
    logic                  rd;
    logic                  wr;

    assign rd = cmd_valid && !cmd_write;
    assign wr = cmd_valid && cmd_write;

    // Positions above the fault field have no source, so they never produce an edge
    genvar i;
    generate
        for (i = 0; i < `FSR_REG_W; i = i + 1)
        begin : g_edge
            if (i < `FSR_FAULT_W)
            begin : g_src
                assign hit[i] = (q.sync_b[i] & ~q.live[i] & q.rise_f[i])
                              | (~q.sync_b[i] & q.live[i] & q.fall_f[i]);
            end
            else
            begin : g_nosrc
                assign hit[i] = 1'b0;
            end
        end
    endgenerate

    assign std_hit = std_src & ~q.std_prev & `FSR_STD_VALID_MASK;

    always_comb
    begin
        next_q = q;
        next_q.sync_a = fault_in;
        next_q.sync_b = q.sync_a;
        next_q.live = q.sync_b;
        next_q.std_prev = std_src;
        if (wr)
        begin
            case (cmd_sel)
                fsr_sel_mask:     next_q.mask = cmd_wdata;
                fsr_sel_rise:     next_q.rise_f = cmd_wdata;
                fsr_sel_fall:     next_q.fall_f = cmd_wdata;
                fsr_sel_std_mask: next_q.std_mask = cmd_wdata[`FSR_STD_W-1:0] & `FSR_STD_VALID_MASK;
                default:          next_q.mask = q.mask;
            endcase
        end
        // A read clears only what it returned; an edge in the same cycle survives
        next_q.events = ((rd && cmd_sel == fsr_sel_events) ? `FSR_ZERO16 : q.events) | hit;
        next_q.std_events = ((rd && cmd_sel == fsr_sel_std_events) ? `FSR_ZERO8 : q.std_events) | std_hit;
        next_q.rsp_valid = rd;
        next_q.rsp_data = `FSR_ZERO16;
        if (rd)
        begin
            case (cmd_sel)
                fsr_sel_live:       next_q.rsp_data = {{(`FSR_REG_W-`FSR_FAULT_W){1'b0}}, q.live};
                fsr_sel_mask:       next_q.rsp_data = q.mask;
                fsr_sel_events:     next_q.rsp_data = q.events;
                fsr_sel_rise:       next_q.rsp_data = q.rise_f;
                fsr_sel_fall:       next_q.rsp_data = q.fall_f;
                fsr_sel_std_events: next_q.rsp_data = {`FSR_ZERO8, q.std_events};
                fsr_sel_std_mask:   next_q.rsp_data = {`FSR_ZERO8, q.std_mask};
                default:            next_q.rsp_data = `FSR_ZERO16;
            endcase
        end
        // Summary follows the new state so it never lags the event register
        next_q.status_byte = `FSR_ZERO8;
        next_q.status_byte[`FSR_STB_FAULT_BIT] = |(next_q.events & next_q.mask);
        next_q.status_byte[`FSR_STB_STD_BIT] = |(next_q.std_events & next_q.std_mask);
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
    assign status_byte = q.status_byte;

    // Checks
    logic [1:0] up_cnt;
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            up_cnt <= 2'h0;
        end
        else if (up_cnt != 2'h3)
        begin
            up_cnt <= up_cnt + 2'h1;
        end
    end

    // Last rise filter write, held apart from the register so a readback has something independent to match
    logic [`FSR_REG_W-1:0] rise_shadow;
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rise_shadow <= `FSR_ZERO16;
        end
        else if (wr && cmd_sel == fsr_sel_rise)
        begin
            rise_shadow <= cmd_wdata;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_live_follows;
        up_cnt == 2'h3 |-> q.live == $past(fault_in, 3);
    endproperty
    a_live_follows: assert property (p_live_follows) else $error("live register lags fault inputs");

    property p_live_read_quiet;
        rd && cmd_sel == fsr_sel_live |=> (q.events & $past(q.events)) == $past(q.events)
            && $stable(q.mask) && $stable(q.rise_f) && $stable(q.fall_f);
    endproperty
    a_live_read_quiet: assert property (p_live_read_quiet) else $error("live read disturbed events");

    property p_live_upper_zero;
        rd && cmd_sel == fsr_sel_live |=> rsp_valid && rsp_data[15:5] == 11'h000;
    endproperty
    a_live_upper_zero: assert property (p_live_upper_zero) else $error("unused live bits not zero");

    property p_edge_sets;
        |hit |=> (q.events & $past(hit)) == $past(hit);
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("qualifying edge not latched");

    property p_fall_write;
        wr && cmd_sel == fsr_sel_fall |=> q.fall_f == $past(cmd_wdata);
    endproperty
    a_fall_write: assert property (p_fall_write) else $error("fall filter write lost");

    property p_sticky;
        !(rd && cmd_sel == fsr_sel_events) |=> (q.events & $past(q.events)) == $past(q.events);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit dropped without read");

    property p_read_clear;
        rd && cmd_sel == fsr_sel_events && hit == 16'h0000 |=> q.events == 16'h0000 && rsp_data == $past(q.events);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("event read did not return and clear");

    property p_summary;
        status_byte[`FSR_STB_FAULT_BIT] == |(q.events & q.mask);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit mismatch");

    property p_std_rise_only;
        ##1 (q.std_events & ~$past(q.std_events))
            == ($past(std_src) & ~$past(q.std_prev) & `FSR_STD_VALID_MASK & q.std_events & ~$past(q.std_events));
    endproperty
    a_std_rise_only: assert property (p_std_rise_only) else $error("standard event set without rise");

    property p_rise_readback;
        rd && cmd_sel == fsr_sel_rise |=> rsp_valid && rsp_data == $past(rise_shadow);
    endproperty
    a_rise_readback: assert property (p_rise_readback) else $error("rise filter readback wrong");

    property p_reset_clear;
        $rose(resetn) |-> q.mask == 16'h0000 && q.events == 16'h0000 && status_byte == 8'h00;
    endproperty
    a_reset_clear: assert property (disable iff (1'b0) p_reset_clear) else $error("reset left state");

    c_fault_rise: cover property (|(hit & q.rise_f & {11'h000, q.sync_b}));
    c_event_read: cover property (rd && cmd_sel == fsr_sel_events && q.events != 16'h0000);
    c_summary_up: cover property ($rose(status_byte[3]));
    c_std_event: cover property ($rose(status_byte[5]));
endmodule // fsr_top
`default_nettype wire

// file: fsr_host_model.sv
// Host model that issues command accesses to the fault status group
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model
(
    input  wire logic             mclk,
    input  wire logic             rsp_valid,
    input  wire logic [15:0]      rsp_data,
    output var  logic             cmd_valid,
    output var  logic             cmd_write,
    output var  fsr_pkg::fsr_sel_e cmd_sel,
    output var  logic [15:0]      cmd_wdata
);
    import fsr_pkg::*;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_sel   = fsr_sel_none;
        cmd_wdata = 16'h0000;
    end
    // One access per call; an idle cycle follows so the strobe is never re-driven in one step
    task automatic access(input logic wr, input fsr_sel_e sel, input logic [15:0] wd, output logic [15:0] rd);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_sel   = sel;
        cmd_wdata = wd;
        @(negedge mclk);
        rd = (rsp_valid === 1'b1) ? rsp_data : 16'hBAD0;
        cmd_valid = 1'b0;
        cmd_sel   = fsr_sel_none;
        // Released data shows the inverse so stale values cannot pass
        cmd_wdata = ~wd;
    endtask
endmodule // fsr_host_model
`default_nettype wire

// file: fault_status_register_group_tb.sv
// Self-checking bench for the fault status register group
`timescale 1ns/1ps
`default_nettype none
module fault_status_register_group_tb;
    import fsr_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [4:0]  fault_in = 5'h00;
    logic [7:0]  std_src = 8'h00;
    logic        cmd_valid, cmd_write, rsp_valid;
    fsr_sel_e    cmd_sel;
    logic [15:0] cmd_wdata, rsp_data, rd, rise, fall, mask, ev;
    logic [7:0]  status_byte;
    integer      miscompares = 0;
    integer      comparisons = 0;
    integer      seed = 61452;
    integer      i;
    always #10 mclk = ~mclk;
    fsr_top u_fsr_top (.mclk(mclk), .resetn(resetn), .fault_in(fault_in), .std_src(std_src),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_byte(status_byte));
    fsr_host_model u_fsr_host_model (.mclk(mclk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input fsr_sel_e s, input logic [15:0] d);
        u_fsr_host_model.access(1'b1, s, d, rd);
    endtask
    task automatic rd_chk(input string what, input fsr_sel_e s, input logic [15:0] exp);
        u_fsr_host_model.access(1'b0, s, 16'h0000, rd);
        check(what, rd, exp);
    endtask
    function automatic logic [15:0] edge_ev(input logic [4:0] o, input logic [4:0] n);
        edge_ev = ev | (rise & {11'h000, ~o & n}) | (fall & {11'h000, o & ~n});
    endfunction
    function automatic logic [15:0] stb(input logic std_sum);
        stb = {10'h000, std_sum, 1'b0, |(ev & mask), 3'h0};
    endfunction
    // Pins cross a two-flop synchroniser, so four cycles cover the event latency
    task automatic set_fault(input logic [4:0] v);
        @(negedge mclk);
        ev = edge_ev(fault_in, v);
        fault_in = v;
        repeat (4) @(negedge mclk);
    endtask
    initial
    begin
        #400000;
        miscompares = miscompares + 1;
        close_out();
    end
    initial
    begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        rise = 16'h0004;
        fall = 16'h0000;
        mask = 16'h0004;
        ev = 16'h0000;
        check("status_byte", {8'h00, status_byte}, 16'h0000);
        rd_chk("rise", fsr_sel_rise, 16'h0000);
        rd_chk("fall", fsr_sel_fall, 16'h0000);
        rd_chk("mask", fsr_sel_mask, 16'h0000);
        rd_chk("events", fsr_sel_events, 16'h0000);
        rd_chk("none", fsr_sel_none, 16'h0000);
        wr(fsr_sel_live, 16'hFFFF);
        rd_chk("live", fsr_sel_live, 16'h0000);
        wr(fsr_sel_rise, rise);
        wr(fsr_sel_mask, mask);
        set_fault(5'h04);
        set_fault(5'h00);
        check("status_byte", {8'h00, status_byte}, stb(1'b0));
        rd_chk("live", fsr_sel_live, 16'h0000);
        rd_chk("events", fsr_sel_events, 16'h0004);
        rd_chk("events", fsr_sel_events, 16'h0000);
        ev = 16'h0000;
        for (i = 0; i < 60; i = i + 1)
        begin
            rise = (i == 0) ? 16'hFFFF : 16'($random(seed));
            fall = (i == 0) ? 16'hFFFF : 16'($random(seed));
            mask = 16'($random(seed));
            wr(fsr_sel_rise, rise);
            wr(fsr_sel_fall, fall);
            wr(fsr_sel_mask, mask);
            rd_chk("rise", fsr_sel_rise, rise);
            rd_chk("fall", fsr_sel_fall, fall);
            rd_chk("mask", fsr_sel_mask, mask);
            set_fault(5'($random(seed)));
            set_fault(5'($random(seed)));
            rd_chk("live", fsr_sel_live, {11'h000, fault_in});
            check("status_byte", {8'h00, status_byte}, stb(1'b0));
            rd_chk("events", fsr_sel_events, ev);
            ev = 16'h0000;
        end
        wr(fsr_sel_std_mask, 16'hFFFF);
        rd_chk("std_mask", fsr_sel_std_mask, 16'h003D);
        std_src = 8'hFF;
        repeat (4) @(negedge mclk);
        check("status_byte", {8'h00, status_byte}, stb(1'b1));
        rd_chk("std_events", fsr_sel_std_events, 16'h003D);
        std_src = 8'h00;
        repeat (4) @(negedge mclk);
        rd_chk("std_events", fsr_sel_std_events, 16'h0000);
        close_out();
    end
endmodule // fault_status_register_group_tb
`default_nettype wire
